// >>> hdl/ard_defs.vh
`ifndef ARD_DEFS_VH
`define ARD_DEFS_VH
// Datapath width
`define ARD_WIDTH       16
`define ARD_MSB         15
`define ARD_CHAN_W      6
// Operation codes presented by the sequencer
`define ARD_OP_W        4
`define ARD_OP_NOP      4'h0
`define ARD_OP_SUBROUTINE_ENTRY_OP        4'h1
`define ARD_OP_MERGE_INPUT_TO_FIRST_ACC   4'h2
`define ARD_OP_MERGE_INPUT_TO_SECOND_ACC  4'h3
`define ARD_OP_OUTPUT_FROM_FIRST_ACC      4'h4
`define ARD_OP_OUTPUT_FROM_SECOND_ACC     4'h5
`define ARD_OP_ROTATE_FIRST_ACC_LEFT      4'h6
`define ARD_OP_ROTATE_FIRST_ACC_RIGHT     4'h7
// Macro entry count supported by options
`define ARD_MACRO_ENTRIES 2048
// Reset values
`define ARD_ZERO        16'h0000
`define ARD_ONES        16'hFFFF
// Panel switch debounce samples
`define ARD_DEB_CNT     4
`endif

// >>> hdl/ard_panel_sw.v
`timescale 1ns/1ps
`default_nettype none
// Synchronise a panel switch and emit a pulse on release after a stable press
module ard_panel_sw #(
  parameter CNT = 4
) (
  // Clock and reset
  input  wire clk,
  input  wire sysRst,
  // Raw switch and release pulse
  input  wire rawSw,
  output reg  released
);
  reg       syncA;
  reg       syncB;
  reg       pressed;
  reg [3:0] stable;

  // Two-stage synchroniser
  always @(posedge clk) begin
    if (sysRst) begin
      syncA <= 1'b0;
      syncB <= 1'b0;
    end else begin
      syncA <= rawSw;
      syncB <= syncA;
    end
  end

  // Press is recognised after CNT stable samples, pulse on release
  always @(posedge clk) begin
    if (sysRst) begin
      stable   <= 4'h0;
      pressed  <= 1'b0;
      released <= 1'b0;
    end else begin
      released <= 1'b0;
      if (syncB != pressed) begin
        if (stable == CNT[3:0] - 4'h1) begin
          stable  <= 4'h0;
          pressed <= syncB;
          released <= pressed & ~syncB;
        end else begin
          stable <= stable + 4'h1;
        end
      end else begin
        stable <= 4'h0;
      end
    end
  end
endmodule // ard_panel_sw
`default_nettype wire

// >>> hdl/ard_datapath.v
// Behaviour
// - Macro entry opcode behaves as no-operation
// - Merge input ORs buffer into A
// - Merge input ORs buffer into B
// - No-operation changes no register state except ioChannel, which takes opChannel
// - Output copies A to buffer, A kept
// - Output copies B to buffer, B kept
// - Rotate A left, bit 15 into 0
// - Rotate A right, bit 0 into 15
// - Load A switch copies switches into A
// - Preset switch turns preset indicator off
// - Displays show bits 15..0, lit is one
// - Switches give word, up is one
// - Load B switch copies switches into B
// - Load address sets counter and address register
// - Load memory increments both, wrapping around
`timescale 1ns/1ps
`default_nettype none
`include "ard_defs.vh"
module ard_datapath #(
  parameter WIDTH  = `ARD_WIDTH,
  parameter CHAN_W = `ARD_CHAN_W,
  parameter DEB    = `ARD_DEB_CNT
) (
  // Clock and reset
  input  wire                  clk,
  input  wire                  sys_rst,
  // Instruction from sequencer, same clock
  input  wire                  execStrobe,
  input  wire [`ARD_OP_W-1:0]  opCode,
  input  wire [CHAN_W-1:0]     opChannel,
  // I/O card side
  input  wire [WIDTH-1:0]      ioBufferIn,     // Valid while ioReadStrobe is high
  output reg  [CHAN_W-1:0]     ioChannel,
  output reg                   ioReadStrobe,
  output reg                   ioWriteStrobe,
  output reg  [WIDTH-1:0]      ioDataOut,
  // Front panel pins
  input  wire [WIDTH-1:0]      switchReg,
  input  wire                  swLoadA,
  input  wire                  swLoadB,
  input  wire                  swLoadAddr,
  input  wire                  swLoadMem,
  input  wire                  swPreset,
  input  wire                  powerOnPreset,
  // Panel displays
  output reg  [WIDTH-1:0]      dispA,
  output reg  [WIDTH-1:0]      dispB,
  output reg  [WIDTH-1:0]      dispP,
  output reg  [WIDTH-1:0]      dispM,
  output reg                   presetLamp
);
  reg  [WIDTH-1:0] accA;
  reg  [WIDTH-1:0] accB;
  reg  [WIDTH-1:0] progCnt;
  reg  [WIDTH-1:0] memAddr;
  reg  [WIDTH-1:0] swSync1;
  reg  [WIDTH-1:0] swSync2;
  reg              porSync1;
  reg              porSync2;
  reg  [WIDTH-1:0] next_accA;
  reg  [WIDTH-1:0] next_accB;
  reg  [WIDTH-1:0] baseA;
  reg  [WIDTH-1:0] baseB;
  reg              readIntoB;
  wire [4:0]       panelRel;
  wire [4:0]       panelRaw;

  assign panelRaw = {swPreset, swLoadMem, swLoadAddr, swLoadB, swLoadA};

  // One synchroniser and release detector per panel switch
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : gSw
      ard_panel_sw #(
        .CNT(DEB)
      ) uSw (
        .clk     (clk),
        .sysRst  (sys_rst),
        .rawSw   (panelRaw[gi]),
        .released(panelRel[gi])
      );
    end
  endgenerate

  // Switch register and power-on preset synchronisers
  always @(posedge clk) begin
    if (sys_rst) begin
      swSync1  <= `ARD_ZERO;
      swSync2  <= `ARD_ZERO;
      porSync1 <= 1'b0;
      porSync2 <= 1'b0;
    end else begin
      swSync1  <= switchReg;
      swSync2  <= swSync1;
      porSync1 <= powerOnPreset;
      porSync2 <= porSync1;
    end
  end

  // Merge the card word one cycle after input, once the card sees its code
  always @* begin
    baseA = accA;
    baseB = accB;
    if (ioReadStrobe) begin
      if (readIntoB) begin
        baseB = accB | ioBufferIn;
      end else begin
        baseA = accA | ioBufferIn;
      end
    end
  end

  // Next accumulator values for each instruction
  always @* begin
    next_accA = baseA;
    next_accB = baseB;
    if (execStrobe) begin
      case (opCode)
        `ARD_OP_ROTATE_FIRST_ACC_LEFT:  next_accA = {baseA[WIDTH-2:0], baseA[WIDTH-1]};
        `ARD_OP_ROTATE_FIRST_ACC_RIGHT: next_accA = {baseA[0], baseA[WIDTH-1:1]};
        // No-operation, macro entry and outputs keep A and B, inputs merge next cycle
        default: begin
          next_accA = baseA;
          next_accB = baseB;
        end
      endcase
    end
  end

  // Accumulators written at execute end, panel loads win over execute
  always @(posedge clk) begin
    if (sys_rst) begin
      accA <= `ARD_ZERO;
      accB <= `ARD_ZERO;
    end else begin
      accA <= next_accA;
      accB <= next_accB;
      if (panelRel[0]) begin
        accA <= swSync2;
      end
      if (panelRel[1]) begin
        accB <= swSync2;
      end
    end
  end

  // Program counter and memory address from panel
  always @(posedge clk) begin
    if (sys_rst) begin
      progCnt <= `ARD_ZERO;
      memAddr <= `ARD_ZERO;
    end else if (panelRel[2]) begin
      progCnt <= swSync2;
      memAddr <= swSync2;
    end else if (panelRel[3]) begin
      progCnt <= progCnt + 16'h0001;
      memAddr <= memAddr + 16'h0001;
    end
  end

  // I/O transfer strobes toward the addressed card
  always @(posedge clk) begin
    if (sys_rst) begin
      ioChannel     <= {CHAN_W{1'b0}};
      ioReadStrobe  <= 1'b0;
      ioWriteStrobe <= 1'b0;
      ioDataOut     <= `ARD_ZERO;
      readIntoB     <= 1'b0;
    end else begin
      ioReadStrobe  <= 1'b0;
      ioWriteStrobe <= 1'b0;
      if (execStrobe) begin
        ioChannel <= opChannel;
        case (opCode)
          `ARD_OP_MERGE_INPUT_TO_FIRST_ACC: begin
            ioReadStrobe <= 1'b1;
            readIntoB    <= 1'b0;
          end
          `ARD_OP_MERGE_INPUT_TO_SECOND_ACC: begin
            ioReadStrobe <= 1'b1;
            readIntoB    <= 1'b1;
          end
          `ARD_OP_OUTPUT_FROM_FIRST_ACC: begin
            ioWriteStrobe <= 1'b1;
            ioDataOut     <= baseA;
          end
          `ARD_OP_OUTPUT_FROM_SECOND_ACC: begin
            ioWriteStrobe <= 1'b1;
            ioDataOut     <= baseB;
          end
          default: ioReadStrobe <= 1'b0;
        endcase
      end
    end
  end

  // Preset lamp set by power-on, cleared by preset release
  always @(posedge clk) begin
    if (sys_rst) begin
      presetLamp <= 1'b1;
    end else if (porSync2) begin
      presetLamp <= 1'b1;
    end else if (panelRel[4]) begin
      presetLamp <= 1'b0;
    end
  end

  // Displays, lit bit is logic one, bit 15 leftmost
  always @(posedge clk) begin
    if (sys_rst) begin
      dispA <= `ARD_ZERO;
      dispB <= `ARD_ZERO;
      dispP <= `ARD_ZERO;
      dispM <= `ARD_ZERO;
    end else begin
      dispA <= accA;
      dispB <= accB;
      dispP <= progCnt;
      dispM <= memAddr;
    end
  end
endmodule // ard_datapath
`default_nettype wire

// >>> dv/ard_card.sv
`timescale 1ns/1ps
`default_nettype none
module ard_card #(
  parameter logic [5:0] CH = 6'h05
) (
  // Bus side
  input  wire logic        clk,
  input  wire logic [5:0]  sel,
  input  wire logic [5:0]  wrChan,
  input  wire logic        wrStrobe,
  input  wire logic [15:0] wrData,
  output logic      [15:0] bufOut
);
  logic [15:0] bufReg = 16'h0F0F;
  // Unselected card shows inverse, never a stale word
  assign bufOut = (sel == CH) ? bufReg : ~bufReg;
  // Latch words addressed to this card
  always @(posedge clk) if (wrStrobe && wrChan == CH) bufReg <= wrData;
endmodule // ard_card
`default_nettype wire

// >>> dv/ard_datapath_props.sv
`timescale 1ns/1ps
`default_nettype none
module ard_datapath_props (
  // Watched ports
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        execStrobe,
  input wire logic [3:0]  opCode,
  input wire logic [5:0]  opChannel,
  input wire logic [15:0] ioBufferIn,
  input wire logic [5:0]  ioChannel,
  input wire logic        ioReadStrobe,
  input wire logic        ioWriteStrobe,
  input wire logic [15:0] dispA,
  input wire logic [15:0] dispB,
  input wire logic        presetLamp
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Lone instruction, so displays show only its effect
  sequence ex(logic [3:0] o);
    execStrobe && opCode == o ##1 !execStrobe;
  endsequence
  chk_merge_first: assert property (ex(4'h2) |=> ##1 dispA == ($past(ioBufferIn, 2) | $past(dispA)))
    else $error("A merge");
  chk_merge_second: assert property (ex(4'h3) |=> ##1 dispB == ($past(ioBufferIn, 2) | $past(dispB)))
    else $error("B merge");
  chk_rotate_left: assert property (ex(4'h6) |=> dispA == {$past(dispA[14:0]), $past(dispA[15])})
    else $error("rot left");
  chk_rotate_right: assert property (ex(4'h7) |=> dispA == {$past(dispA[0]), $past(dispA[15:1])})
    else $error("rot right");
  chk_nop_hold: assert property ((ex(4'h0) or ex(4'h1)) |=> $stable(dispA) && $stable(dispB))
    else $error("nop change");
  chk_rd_pulse: assert property (ioReadStrobe == $past(execStrobe && opCode inside {4'h2, 4'h3}))
    else $error("read pulse");
  chk_wr_pulse: assert property (ioWriteStrobe == $past(execStrobe && opCode inside {4'h4, 4'h5}))
    else $error("write pulse");
  chk_chan_sel: assert property (execStrobe |=> ioChannel == $past(opChannel))
    else $error("channel");
  cover property (ex(4'h6));
  cover property (ioWriteStrobe);
  cover property ($fell(presetLamp));
endmodule // ard_datapath_props
bind ard_datapath ard_datapath_props u_props (.clk, .sys_rst, .execStrobe, .opCode, .opChannel, .ioBufferIn,
  .ioChannel, .ioReadStrobe, .ioWriteStrobe, .dispA, .dispB, .presetLamp);
`default_nettype wire

// >>> dv/ard_datapath_test.sv
`timescale 1ns/1ps
`default_nettype none
module ard_datapath_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        exe = 1'b0;
  logic [3:0]  op = 4'h0;
  logic [4:0]  sw = 5'h00;
  logic [15:0] swReg = 16'h0000;
  logic [5:0]  ch = 6'h05;
  logic        por = 1'b0;
  wire  [15:0] bufIn, dOut, dA, dB, dP, dM;
  wire  [5:0]  chan;
  wire         rdS, wrS, lamp;
  int          badCount = 0;
  int          totalChecks = 0;
  // Clock
  always #2.5 clk = ~clk;
  ard_datapath dut (.clk(clk), .sys_rst(rst), .execStrobe(exe), .opCode(op), .opChannel(ch),
    .ioBufferIn(bufIn), .ioChannel(chan), .ioReadStrobe(rdS), .ioWriteStrobe(wrS), .ioDataOut(dOut),
    .switchReg(swReg), .swLoadA(sw[0]), .swLoadB(sw[1]), .swLoadAddr(sw[2]), .swLoadMem(sw[3]),
    .swPreset(sw[4]), .powerOnPreset(por), .dispA(dA), .dispB(dB), .dispP(dP), .dispM(dM), .presetLamp(lamp));
  ard_card card (.clk(clk), .sel(chan), .wrChan(chan), .wrStrobe(wrS), .wrData(dOut), .bufOut(bufIn));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    totalChecks++;
    if (g !== e) begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic press(input int n, input logic [15:0] v);
    swReg = v;
    sw[n] = 1'b1;
    repeat (16) @(negedge clk);
    sw[n] = 1'b0;
    repeat (24) @(negedge clk);
  endtask
  task automatic exec(input logic [3:0] o);
    exe = 1'b1;
    op = o;
    @(negedge clk);
    exe = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic test_panel;
    press(0, 16'hFFFF);
    chk("A", 16'hFFFF, dA);
    press(0, 16'h0000);
    chk("A", 16'h0000, dA);
    press(1, 16'h1234);
    chk("B", 16'h1234, dB);
    press(2, 16'hFFF8);
    chk("P", 16'hFFF8, dP);
    chk("M", 16'hFFF8, dM);
    repeat (7) press(3, 16'h0000);
    chk("M", 16'hFFFF, dM);
    press(3, 16'h0000);
    chk("P", 16'h0000, dP);
    chk("M", 16'h0000, dM);
    chk("lamp", 16'h0001, {15'h0000, lamp});
    press(4, 16'h0000);
    chk("lamp", 16'h0000, {15'h0000, lamp});
    por = 1'b1;
    repeat (4) @(negedge clk);
    por = 1'b0;
    repeat (4) @(negedge clk);
    chk("lamp", 16'h0001, {15'h0000, lamp});
    press(4, 16'h0000);
    chk("lamp", 16'h0000, {15'h0000, lamp});
    $display("test_panel done");
  endtask
  task automatic test_io;
    press(0, 16'h8001);
    exec(4'h2);
    chk("A", 16'h8F0F, dA);
    exec(4'h0);
    exec(4'h1);
    chk("A", 16'h8F0F, dA);
    chk("B", 16'h1234, dB);
    exec(4'h6);
    chk("A", 16'h1E1F, dA);
    exec(4'h7);
    chk("A", 16'h8F0F, dA);
    exec(4'h4);
    chk("card", 16'h8F0F, card.bufReg);
    chk("out", 16'h8F0F, dOut);
    exec(4'h3);
    chk("B", 16'h9F3F, dB);
    exec(4'h5);
    chk("card", 16'h9F3F, card.bufReg);
    ch = 6'h06;
    exec(4'h4);
    chk("chan", 16'h0006, {10'h000, chan});
    chk("card", 16'h9F3F, card.bufReg);
    ch = 6'h05;
    $display("test_io done");
  endtask
  task automatic tallyAndFinish;
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    test_panel;
    test_io;
    tallyAndFinish;
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    badCount++;
    tallyAndFinish;
  end
endmodule // ard_datapath_test
`default_nettype wire
